// ---- rtl/fupc_flash_guard.v ----
// Purpose: flash unlock sequencer, protection checks and operation timing
// Assumes: register file writes arrive as one-cycle strobes on clk_sys;
//          flash cell array lives outside and follows flashProg/flashErase
// Notes:   the flash array itself, the status layout and bypass mode are out
`timescale 1ns/1ps
`default_nettype none
`include "fupc_regs.vh"
module fupc_flash_guard #(
    parameter MEM_KB      = 8,
    parameter ADDR_BITS   = 13,
    parameter PROG_US     = `FUPC_T_PROG_US,
    parameter ERASE_US    = `FUPC_T_ERASE_US,
    parameter MASS_US     = `FUPC_T_MASS_US
) (
    // clock and reset
    input  wire                 clk_sys,
    input  wire                 rst,
    // register file port
    input  wire                 regWrite,
    input  wire                 regRead,
    input  wire [11:0]          regAddr,
    input  wire [7:0]           regWdata,
    input  wire                 regFromDebug,
    output reg  [7:0]           regRdata,
    // option bits, sampled from the option bytes
    input  wire                 readout_guard_option,
    input  wire                 program_guard_option,
    // byte program request (flash address space)
    input  wire                 progReq,
    input  wire [15:0]          progAddr,
    input  wire [7:0]           progData,
    input  wire [7:0]           progOldData,
    input  wire                 progFromDebug,
    // flash read request from the debug interface
    input  wire                 dbgReadReq,
    input  wire [15:0]          dbgReadAddr,
    output reg                  dbgReadDeny,
    // flash array control
    output reg                  flashProg,
    output reg                  flashErase,
    output reg                  flashMass,
    output reg  [15:0]          flashAddr,
    output reg  [7:0]           flashData,
    output reg                  progRefused,
    // cpu and status
    output reg                  cpuStall,
    output reg                  ctrlUnlocked,
    output reg  [7:0]           sector_write_lock
);
    localparam MEM_BYTES  = MEM_KB * 1024;
    localparam SECT_RAW   = MEM_BYTES / 8;
    // sector never smaller than a page
    localparam SECT_BYTES = (SECT_RAW < `FUPC_PAGE_BYTES) ?
                            `FUPC_PAGE_BYTES : SECT_RAW;
    localparam PAGE_SH    = 9;
    localparam SECT_SH    = (SECT_BYTES == 1024) ? 10 : 9;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [7:0]  pageSel;
    reg  [7:0]  activePage;
    reg         sectSelect;
    reg  [15:0] khzValue;
    reg         pageIsActive;
    reg         next_pageIsActive;
    reg  [15:0] loadUs;
    reg         opStart;
    reg         busyMass;

    wire        usTick;
    wire        opRunning;
    wire        opDone;

    wire cmdWrite  = regWrite && (regAddr == `FUPC_ADDR_CMD);
    wire pageWrite = regWrite && (regAddr == `FUPC_ADDR_PAGESEL);

    // sector index of a page, then its lock bit
    wire [2:0] actSector = (SECT_SH == 10) ? activePage[3:1] : activePage[2:0];
    wire       actLocked = sector_write_lock[actSector];
    wire [2:0] progSector = progAddr[SECT_SH+2 -: 3];
    wire       progInMem  = (progAddr < MEM_BYTES);
    wire       progIsOpt  = (progAddr < `FUPC_OPT_BYTES);
    wire       progIsInfo = (progAddr >= `FUPC_INFO_BASE);

    // cpu byte writes: page, guard and sector checks; debugger skips them
    wire progInPage = (progAddr[15:PAGE_SH] == {1'b0, activePage[6:0]});
    wire progRefusedNow = progFromDebug ? !progInMem :
        (!program_guard_option || sector_write_lock[progSector] ||
         !progInPage || !progInMem || progIsInfo);

    fupc_tick_gen u_tick (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .run      (opRunning),
        .khzValue (khzValue),
        .usTick   (usTick)
    );

    fupc_op_timer #(.WIDTH(16)) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (opStart),
        .loadUs  (loadUs),
        .usTick  (usTick),
        .running (opRunning),
        .done    (opDone)
    );

    // sequencer
    always @* begin
        next_state        = state;
        next_pageIsActive = pageIsActive;
        opStart           = 1'b0;
        loadUs            = PROG_US[15:0];
        if (state == `FUPC_ST_BUSY) begin
            if (opDone) begin
                next_state        = flashProg ? `FUPC_ST_ACTIVE
                                              : `FUPC_ST_LOCKED;
                next_pageIsActive = flashProg;
            end
        end else if (cmdWrite) begin
            next_state        = `FUPC_ST_LOCKED;
            next_pageIsActive = 1'b0;
            case (state)
                `FUPC_ST_LOCKED: begin
                    if (regWdata == `FUPC_CMD_UNLOCK1)
                        next_state = `FUPC_ST_UNLOCK1;
                end
                `FUPC_ST_UNLOCK1: begin
                    if (regWdata == `FUPC_CMD_UNLOCK2)
                        next_state = regFromDebug ? `FUPC_ST_MASS_OK
                                                  : `FUPC_ST_UNLOCK2;
                end
                `FUPC_ST_ACTIVE, `FUPC_ST_MASS_OK: begin
                    if (regWdata == `FUPC_CMD_PAGE_ERASE && pageIsActive &&
                        (regFromDebug ||
                         (program_guard_option && !actLocked))) begin
                        next_state = `FUPC_ST_BUSY;
                        opStart    = 1'b1;
                        loadUs     = ERASE_US[15:0];
                    end else if (regWdata == `FUPC_CMD_MASS_ERASE &&
                                 regFromDebug) begin
                        next_state = `FUPC_ST_BUSY;
                        opStart    = 1'b1;
                        loadUs     = MASS_US[15:0];
                    end
                end
                default: next_state = `FUPC_ST_LOCKED;
            endcase
        end else if (pageWrite && !sectSelect) begin
            if (state == `FUPC_ST_UNLOCK2) begin
                // second page write must match the first
                next_pageIsActive = (regWdata == pageSel);
                next_state = (regWdata == pageSel) ? `FUPC_ST_ACTIVE
                                                   : `FUPC_ST_LOCKED;
            end else if (state == `FUPC_ST_MASS_OK) begin
                next_pageIsActive = 1'b1;
            end
        end else if (progReq && state == `FUPC_ST_ACTIVE &&
                     !progRefusedNow) begin
            next_state = `FUPC_ST_BUSY;
            opStart    = 1'b1;
            loadUs     = PROG_US[15:0];
        end else if (progReq && state == `FUPC_ST_MASS_OK &&
                     progFromDebug && progInMem) begin
            next_state = `FUPC_ST_BUSY;
            opStart    = 1'b1;
            loadUs     = PROG_US[15:0];
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state             <= `FUPC_ST_LOCKED;
            pageIsActive      <= 1'b0;
            pageSel           <= 8'h00;
            activePage        <= 8'h00;
            sectSelect        <= 1'b0;
            khzValue          <= 16'h0000;
            sector_write_lock <= `FUPC_SECTOR_RESET;
            flashProg         <= 1'b0;
            flashErase        <= 1'b0;
            flashMass         <= 1'b0;
            flashAddr         <= 16'h0000;
            flashData         <= 8'h00;
            progRefused       <= 1'b0;
            cpuStall          <= 1'b0;
            ctrlUnlocked      <= 1'b0;
            regRdata          <= 8'h00;
            dbgReadDeny       <= 1'b0;
            busyMass          <= 1'b0;
        end else begin
            state        <= next_state;
            pageIsActive <= next_pageIsActive;
            ctrlUnlocked <= (next_state != `FUPC_ST_LOCKED);
            cpuStall     <= (next_state == `FUPC_ST_BUSY);
            if (cmdWrite && state != `FUPC_ST_BUSY)
                sectSelect <= (regWdata == `FUPC_CMD_SECT_SEL);
            if (pageWrite && sectSelect) begin
                if (regFromDebug)
                    sector_write_lock <= regWdata;
                else
                    sector_write_lock <= sector_write_lock | regWdata;
            end else if (pageWrite && (state == `FUPC_ST_LOCKED ||
                         state == `FUPC_ST_UNLOCK2 || regFromDebug)) begin
                pageSel <= regWdata;
            end
            if (pageWrite && !sectSelect && next_pageIsActive &&
                state != `FUPC_ST_ACTIVE)
                activePage <= regWdata;
            if (regWrite && regAddr == `FUPC_ADDR_KHZ_HI)
                khzValue[15:8] <= regWdata;
            if (regWrite && regAddr == `FUPC_ADDR_KHZ_LO)
                khzValue[7:0] <= regWdata;
            if (regRead) begin
                case (regAddr)
                    `FUPC_ADDR_CMD:     regRdata <= {5'h00, state};
                    `FUPC_ADDR_PAGESEL: regRdata <= sectSelect ?
                                        sector_write_lock : pageSel;
                    `FUPC_ADDR_KHZ_HI:  regRdata <= khzValue[15:8];
                    `FUPC_ADDR_KHZ_LO:  regRdata <= khzValue[7:0];
                    default:            regRdata <= 8'h00;
                endcase
            end
            // user code hidden from the debugger when read guard is set
            dbgReadDeny <= dbgReadReq && readout_guard_option &&
                           (dbgReadAddr < MEM_BYTES);
            progRefused <= progReq &&
                           !(state == `FUPC_ST_ACTIVE && !progRefusedNow) &&
                           !(state == `FUPC_ST_MASS_OK && progFromDebug &&
                             progInMem);
            if (opStart) begin
                busyMass   <= (loadUs == MASS_US[15:0]);
                flashErase <= (loadUs != PROG_US[15:0]);
                flashMass  <= (loadUs == MASS_US[15:0]);
                flashProg  <= (loadUs == PROG_US[15:0]);
                flashAddr  <= (loadUs == PROG_US[15:0]) ? progAddr :
                              {activePage[6:0], 9'h000};
                // programming can only clear bits
                flashData  <= (loadUs == PROG_US[15:0]) ?
                              (progData & progOldData) : `FUPC_FILL_ERASED;
            end else if (opDone) begin
                flashProg  <= 1'b0;
                flashErase <= 1'b0;
                flashMass  <= 1'b0;
                busyMass   <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/fupc_regs.vh ----
// Purpose: register addresses, command codes and timing for the flash guard
// Assumes: 12-bit register file addresses, 8-bit data
// Notes:   timing figures are in microseconds, scaled by the kHz value
`ifndef FUPC_REGS_VH
`define FUPC_REGS_VH

`define FUPC_ADDR_CMD        12'hFF8
`define FUPC_ADDR_PAGESEL    12'hFF9
`define FUPC_ADDR_KHZ_HI     12'hFFA
`define FUPC_ADDR_KHZ_LO     12'hFFB

`define FUPC_CMD_UNLOCK1     8'h73
`define FUPC_CMD_UNLOCK2     8'h8C
`define FUPC_CMD_PAGE_ERASE  8'h95
`define FUPC_CMD_MASS_ERASE  8'h63
`define FUPC_CMD_SECT_SEL    8'h5E
`define FUPC_CMD_RESET       8'h00

`define FUPC_PAGE_BYTES      512
`define FUPC_ROW_BYTES       64
`define FUPC_OPT_BYTES       2
`define FUPC_INFO_BASE       16'hFE00
`define FUPC_INFO_LAST       16'hFFFF
`define FUPC_FILL_ERASED     8'hFF

`define FUPC_SECTOR_RESET    8'h00

`define FUPC_T_PROG_US       32'd40
`define FUPC_T_ERASE_US      32'd10000
`define FUPC_T_MASS_US       32'd20000

`define FUPC_ST_LOCKED       3'h0
`define FUPC_ST_UNLOCK1      3'h1
`define FUPC_ST_UNLOCK2      3'h2
`define FUPC_ST_ACTIVE       3'h3
`define FUPC_ST_BUSY         3'h4
`define FUPC_ST_MASS_OK      3'h5

`endif

// ---- rtl/fupc_tick_gen.v ----
// Purpose: one-cycle pulse every microsecond from the kHz frequency value
// Assumes: khzValue holds the system clock in kHz
// Notes:   a fractional accumulator keeps long-term accuracy
`timescale 1ns/1ps
`default_nettype none
module fupc_tick_gen (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // control
    input  wire        run,
    input  wire [15:0] khzValue,
    // tick
    output reg         usTick
);
    // each cycle adds 1000 ns-milli units; a tick each khz*... in milli-us
    reg  [25:0] acc;
    wire [25:0] sum    = acc + 26'd1000;
    wire [25:0] period = {10'h000, khzValue};

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc    <= 26'h0000000;
            usTick <= 1'b0;
        end else if (!run) begin
            acc    <= 26'h0000000;
            usTick <= 1'b0;
        end else if (sum >= period) begin
            acc    <= sum - period;
            usTick <= 1'b1;
        end else begin
            acc    <= sum;
            usTick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/fupc_op_timer.v ----
// Purpose: counts microsecond ticks for one program or erase pulse
// Assumes: start is a one-cycle pulse, usTick from the tick generator
// Notes:   done pulses once when the loaded count runs out
`timescale 1ns/1ps
`default_nettype none
module fupc_op_timer #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    // control
    input  wire             start,
    input  wire [WIDTH-1:0] loadUs,
    input  wire             usTick,
    // status
    output reg              running,
    output reg              done
);
    reg [WIDTH-1:0] remain;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            remain  <= {WIDTH{1'b0}};
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                remain  <= loadUs;
                running <= 1'b1;
            end else if (running && usTick) begin
                if (remain <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end
                remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/fupc_guard_checker.sv ----
// Purpose: concurrent checks on the flash guard ports
// Assumes: async active-high reset, one clock domain
// Notes:   program pulse bound assumes the short bench timing
`timescale 1ns/1ps
`default_nettype none
`include "fupc_regs.vh"
module fupc_guard_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // register file port
    input wire logic        regWrite,
    input wire logic [11:0] regAddr,
    input wire logic [7:0]  regWdata,
    input wire logic        regFromDebug,
    // options and requests
    input wire logic        readout_guard_option,
    input wire logic        program_guard_option,
    input wire logic        progReq,
    input wire logic        progFromDebug,
    input wire logic        dbgReadReq,
    input wire logic [15:0] dbgReadAddr,
    // design outputs
    input wire logic        dbgReadDeny,
    input wire logic        flashProg,
    input wire logic        flashErase,
    input wire logic        flashMass,
    input wire logic        progRefused,
    input wire logic        cpuStall,
    input wire logic        ctrlUnlocked,
    input wire logic [7:0]  sector_write_lock
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic afterRst;
    logic dbgCmdWr;
    // high at the first edge after each reset release
    always @(posedge clk_sys or posedge rst) begin
        if (rst) afterRst <= 1'b1;
        else afterRst <= 1'b0;
    end
    always @(posedge clk_sys) begin
        dbgCmdWr <= regWrite && regFromDebug && regAddr == `FUPC_ADDR_CMD;
    end
    AST_RESET_LOCKED: assert property (afterRst |-> !ctrlUnlocked)
        else $error("controller not locked after reset");
    AST_RESET_CLEAR: assert property (afterRst |-> sector_write_lock == 8'h00)
        else $error("sector locks not clear after reset");
    AST_SET_ONLY: assert property (!$past(regFromDebug) |->
        (($past(sector_write_lock) & ~sector_write_lock) == 8'h00))
        else $error("sector lock bit cleared by user write");
    AST_RELOCK_CMD: assert property (regWrite && !cpuStall &&
        regAddr == `FUPC_ADDR_CMD && regWdata == 8'h00 |=> !ctrlUnlocked)
        else $error("reset command did not relock");
    AST_MASS_DEBUG: assert property ($rose(flashMass) |-> dbgCmdWr)
        else $error("mass erase without debugger command");
    AST_GUARD_BLOCK: assert property (progReq && !progFromDebug &&
        !program_guard_option && !cpuStall |=> progRefused && !flashProg)
        else $error("program allowed with guard option clear");
    AST_STALL_OP: assert property (flashProg || flashErase || flashMass
        |-> cpuStall)
        else $error("cpu not stalled during operation");
    AST_READ_DENY: assert property (dbgReadReq && readout_guard_option &&
        dbgReadAddr < 16'h2000 |=> dbgReadDeny)
        else $error("guarded debugger read not denied");
    AST_READ_OPEN: assert property (dbgReadReq && !readout_guard_option
        |=> !dbgReadDeny)
        else $error("unguarded debugger read denied");
    AST_ERASE_RELOCK: assert property ($fell(flashErase) |-> ##[0:2] !ctrlUnlocked)
        else $error("no relock after page erase");
    AST_ERASE_UNLOCKED: assert property ($rose(flashErase) |-> $past(ctrlUnlocked))
        else $error("erase started while locked");
    AST_PROG_BOUND: assert property ($rose(flashProg) |->
        flashProg[*3] ##[1:40] !flashProg)
        else $error("program pulse length out of range");
endmodule
bind fupc_flash_guard fupc_guard_checker i_fupc_guard_checker (.*);
`default_nettype wire

// ---- tb/fupc_flash_model.sv ----
// Purpose: flash cell array following the guard's control outputs
// Assumes: 8 KB array, erase address names its page
// Notes:   cells change at the start of each operation
`timescale 1ns/1ps
`default_nettype none
module fupc_flash_model (
    // clock
    input wire logic        clk_sys,
    // array control
    input wire logic        flashProg,
    input wire logic        flashErase,
    input wire logic        flashMass,
    input wire logic [15:0] flashAddr,
    input wire logic [7:0]  flashData,
    // current cell value
    input wire logic [15:0] peekAddr,
    output logic [7:0]      peekData
);
    logic [7:0] cells [0:8191];
    logic       progDly = 1'b0;
    logic       eraseDly = 1'b0;
    logic       massDly = 1'b0;
    initial for (int i = 0; i < 8192; i++) cells[i] = 8'hFF;
    assign peekData = cells[peekAddr[12:0]];
    always @(posedge clk_sys) begin
        progDly <= flashProg;
        eraseDly <= flashErase;
        massDly <= flashMass;
        // programming can only clear bits
        if (flashProg && !progDly)
            cells[flashAddr[12:0]] <= cells[flashAddr[12:0]] & flashData;
        if (flashErase && !eraseDly)
            for (int i = 0; i < 512; i++)
                cells[{flashAddr[12:9], i[8:0]}] <= 8'hFF;
        if (flashMass && !massDly)
            for (int i = 0; i < 8192; i++) cells[i] <= 8'hFF;
    end
endmodule
`default_nettype wire

// ---- tb/flash_unlock_and_protect_ctrl_tb_top.sv ----
// Purpose: directed register sequences against the flash guard
// Assumes: kHz value 10000, the tick counts ten cycles per microsecond
// Notes:   short operation times keep the run small
`timescale 1ns/1ps
`default_nettype none
`include "fupc_regs.vh"
module flash_unlock_and_protect_ctrl_tb_top;
    logic        clk_sys, rst, regWrite, regRead, regFromDebug;
    logic [11:0] regAddr;
    logic [7:0]  regWdata, regRdata, progData, progOldData, flashData;
    logic [7:0]  sector_write_lock;
    logic        readout_guard_option, program_guard_option;
    logic        progReq, progFromDebug, dbgReadReq, dbgReadDeny;
    logic [15:0] progAddr, dbgReadAddr, flashAddr;
    logic        flashProg, flashErase, flashMass, progRefused;
    logic        cpuStall, ctrlUnlocked;
    int          errorCnt = 0;
    int          samplesChecked = 0;
    fupc_flash_guard #(.PROG_US(2), .ERASE_US(3), .MASS_US(4)) i_fupc_flash_guard (
        .clk_sys(clk_sys), .rst(rst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regFromDebug(regFromDebug),
        .regRdata(regRdata), .readout_guard_option(readout_guard_option),
        .program_guard_option(program_guard_option), .progReq(progReq),
        .progAddr(progAddr), .progData(progData), .progOldData(progOldData),
        .progFromDebug(progFromDebug), .dbgReadReq(dbgReadReq),
        .dbgReadAddr(dbgReadAddr), .dbgReadDeny(dbgReadDeny),
        .flashProg(flashProg), .flashErase(flashErase), .flashMass(flashMass),
        .flashAddr(flashAddr), .flashData(flashData), .progRefused(progRefused),
        .cpuStall(cpuStall), .ctrlUnlocked(ctrlUnlocked),
        .sector_write_lock(sector_write_lock));
    fupc_flash_model i_fupc_flash_model (.clk_sys(clk_sys),
        .flashProg(flashProg), .flashErase(flashErase), .flashMass(flashMass),
        .flashAddr(flashAddr), .flashData(flashData), .peekAddr(progAddr),
        .peekData(progOldData));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: %s got %h", $time, msg, got);
        end
    endtask
    // idle cycle first so the strobe never toggles twice in one step
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 regAddr = a; regWdata = d; regWrite = 1'b1;
        @(posedge clk_sys);
        #1 regWrite = 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        #1 regAddr = a; regRead = 1'b1;
        @(posedge clk_sys);
        #1 regRead = 1'b0;
        chk(16'(regRdata), 16'(exp), "register read");
    endtask
    task prog(input logic [15:0] a, input logic [7:0] d, input logic dbg);
        @(posedge clk_sys);
        #1 progAddr = a; progData = d; progFromDebug = dbg; progReq = 1'b1;
        @(posedge clk_sys);
        #1 progReq = 1'b0;
    endtask
    task unlock(input logic [7:0] p1, input logic [7:0] p2);
        wr(`FUPC_ADDR_PAGESEL, p1);
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_UNLOCK1);
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_UNLOCK2);
        wr(`FUPC_ADDR_PAGESEL, p2);
    endtask
    task wait_idle;
        int n;
        for (n = 0; n < 4000 && cpuStall !== 1'b0; n++) @(posedge clk_sys);
        #1;
        if (n == 4000) begin
            errorCnt++;
            $display("mismatch at %0t: operation never finished", $time);
            wrap_up();
        end
    endtask
    task dread(input logic g, input logic exp);
        @(posedge clk_sys);
        #1 readout_guard_option = g; dbgReadAddr = 16'h0100; dbgReadReq = 1'b1;
        @(posedge clk_sys);
        #1 dbgReadReq = 1'b0;
        chk(16'(dbgReadDeny), 16'(exp), "debugger read deny");
    endtask
    initial begin
        rst = 1'b1; regWrite = 1'b0; regRead = 1'b0; regFromDebug = 1'b0;
        regAddr = 12'h000; regWdata = 8'h00; progReq = 1'b0;
        progAddr = 16'h0000; progData = 8'h00; progFromDebug = 1'b0;
        dbgReadReq = 1'b0; dbgReadAddr = 16'h0000;
        readout_guard_option = 1'b0; program_guard_option = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 rst = 1'b0;
        chk(16'(ctrlUnlocked), 16'h0000, "locked after reset");
        chk(16'(sector_write_lock), 16'h0000, "locks after reset");
        // clock value kept inside the supported range for operations
        wr(`FUPC_ADDR_KHZ_HI, 8'h27);
        wr(`FUPC_ADDR_KHZ_LO, 8'h10);
        unlock(8'h02, 8'h02);
        chk(16'(ctrlUnlocked), 16'h0001, "page unlock");
        rd(`FUPC_ADDR_CMD, 8'h03);
        prog(16'h0405, 8'h3C, 1'b0);
        chk(16'(flashProg), 16'h0001, "byte program start");
        wait_idle();
        chk(16'(progOldData), 16'h003C, "programmed byte");
        prog(16'h0406, 8'hA5, 1'b0);
        wait_idle();
        chk(16'(ctrlUnlocked), 16'h0001, "page stays open");
        prog(16'h0405, 8'hF0, 1'b0);
        wait_idle();
        chk(16'(progOldData), 16'h0030, "bits only cleared");
        prog(16'h0600, 8'h00, 1'b0);
        chk(16'(progRefused), 16'h0001, "byte outside page");
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_PAGE_ERASE);
        chk(16'(flashErase), 16'h0001, "page erase start");
        wait_idle();
        progAddr = 16'h0405;
        #1 chk(16'(progOldData), 16'h00FF, "erased byte");
        chk(16'(ctrlUnlocked), 16'h0000, "locked after erase");
        $display("test program and erase done");
        unlock(8'h02, 8'h03);
        chk(16'(ctrlUnlocked), 16'h0000, "page mismatch");
        unlock(8'h02, 8'h02);
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_RESET);
        chk(16'(ctrlUnlocked), 16'h0000, "stray command");
        unlock(8'h02, 8'h02);
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_MASS_ERASE);
        chk(16'(flashMass), 16'h0000, "user mass erase");
        program_guard_option = 1'b0;
        unlock(8'h02, 8'h02);
        prog(16'h0410, 8'h00, 1'b0);
        chk(16'(progRefused), 16'h0001, "guard option clear");
        program_guard_option = 1'b1;
        $display("test lock sequence done");
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_RESET);
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_SECT_SEL);
        wr(`FUPC_ADDR_PAGESEL, 8'h02);
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_RESET);
        chk(16'(sector_write_lock), 16'h0002, "sector lock set");
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_SECT_SEL);
        wr(`FUPC_ADDR_PAGESEL, 8'h01);
        wr(`FUPC_ADDR_PAGESEL, 8'h00);
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_RESET);
        chk(16'(sector_write_lock), 16'h0003, "locks only set");
        unlock(8'h02, 8'h02);
        prog(16'h0410, 8'h00, 1'b0);
        chk(16'(progRefused), 16'h0001, "protected sector write");
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_PAGE_ERASE);
        chk(16'(flashErase), 16'h0000, "protected sector erase");
        regFromDebug = 1'b1;
        wr(`FUPC_ADDR_PAGESEL, 8'h02);
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_UNLOCK1);
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_UNLOCK2);
        prog(16'h0410, 8'h55, 1'b1);
        chk(16'(flashProg), 16'h0001, "debugger program");
        wait_idle();
        wr(`FUPC_ADDR_CMD, `FUPC_CMD_MASS_ERASE);
        chk(16'(flashMass), 16'h0001, "debugger mass erase");
        wait_idle();
        regFromDebug = 1'b0;
        chk(16'(progOldData), 16'h00FF, "mass erased byte");
        $display("test sector protect done");
        dread(1'b1, 1'b1);
        dread(1'b0, 1'b0);
        #1 rst = 1'b1;
        @(posedge clk_sys);
        #1 rst = 1'b0;
        chk(16'(sector_write_lock), 16'h0000, "locks lost on reset");
        $display("test read guard and reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
